// >>> ddsl_params.svh
`ifndef DDSL_PARAMS_SVH
`define DDSL_PARAMS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DDSL_FRAME_BITS     24
`define DDSL_CODE_BITS      16
`define DDSL_CHSEL_POS      23
`define DDSL_BOTH_POS       21
`define DDSL_CODE_MSB       15

// ----------------------------------------------------------------
// reset codes
// ----------------------------------------------------------------
`define DDSL_ZERO_CODE      16'h0000
`define DDSL_MID_CODE       16'h8000

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DDSL_OFF_CTRL       4'h0
`define DDSL_OFF_STATUS     4'h1
`define DDSL_OFF_SHIFT      4'h2
`define DDSL_OFF_IN_A       4'h3
`define DDSL_OFF_IN_B       4'h4
`define DDSL_OFF_OUT_A      4'h5
`define DDSL_OFF_OUT_B      4'h6
`define DDSL_CTRL_SOFT_RST  0
`define DDSL_CTRL_RSTSELSW  1
`define DDSL_BAD_ADDR_DATA  32'hdead_0bad

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DDSL_CLK_NS         100
`define DDSL_SDO_MAX_NS     30

`endif

// >>> ddsl_pkg.sv
package ddsl_pkg;
  typedef logic [15:0] ddsl_code_t;
  typedef logic [23:0] ddsl_frame_t;
  typedef enum logic [1:0] {
    DDSL_DEST_NONE,
    DDSL_DEST_A,
    DDSL_DEST_B,
    DDSL_DEST_BOTH
  } ddsl_dest_t;
endpackage : ddsl_pkg

// >>> ddsl_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// two flop synchroniser with edge outputs
// ----------------------------------------------------------------
module ddsl_sync2 #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk_i,
  // async levels in
  input  wire logic [WIDTH-1:0] async_i,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;
  logic [WIDTH-1:0] last_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // no reset: the chain settles within three cycles of power up
  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
    last_q <= last_d;
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
endmodule : ddsl_sync2
`default_nettype wire

// >>> ddsl_core.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ddsl_params.svh"
// Notes on behaviour
// - frame is 24 serial bits
// - select B23, both flag B21, code low sixteen
// - shift serial_in on each effective clock rise
// - load strobe low copies code, level sensitive
// - select 0 writes A, 1 writes B
// - both flag high loads both registers
// - update strobe rise copies both outputs together
// - input writes never disturb output registers
// - shift clock is select OR serial clock
// - select rising with clock low shifts once
// - shifting during load follows into inputs
// - reset rising edge, independent of strobes
// - reset with level select and RSTSELSW both low gives 0000
// - reset with level select high gives 8000
// - reset leaves shift register untouched
// - serial_out driven from final shift stage
// - code is straight binary of 65536 steps
module ddsl_core #(
  parameter int FRAME_BITS = `DDSL_FRAME_BITS,
  parameter int CODE_BITS  = `DDSL_CODE_BITS
) (
  // clock and bus reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  // converter pins, asynchronous to clock_i
  input  wire logic                   select_n_i,
  input  wire logic                   serial_clk_i,
  input  wire logic                   serial_in_i,
  input  wire logic                   load_n_i,
  input  wire logic                   output_update_strobe_i,
  input  wire logic                   dev_reset_i,
  input  wire logic                   reset_level_select_i,
  // serial chain out
  output logic                        serial_out_o,
  // output register codes for the converter
  output ddsl_pkg::ddsl_code_t        code_a_o,
  output ddsl_pkg::ddsl_code_t        code_b_o,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // the pin clock must stay well below clock_i; 800 ns pin period vs 100 ns
  logic [6:0] pin_lvl;
  logic [6:0] pin_rise;

  ddsl_sync2 #(.WIDTH(7)) u_sync (
    .clk_i   (clock_i),
    .async_i ({reset_level_select_i, dev_reset_i, output_update_strobe_i,
               load_n_i, serial_in_i, serial_clk_i, select_n_i}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise)
  );

  logic sel_n_s;
  logic sclk_s;
  logic sdi_s;
  logic load_n_s;
  logic upd_rise;
  logic rst_rise;
  logic reset_level_select_s;

  assign sel_n_s  = pin_lvl[0];
  assign sclk_s   = pin_lvl[1];
  assign sdi_s    = pin_lvl[2];
  assign load_n_s = pin_lvl[3];
  assign upd_rise = pin_rise[4];
  assign rst_rise = pin_rise[5];
  assign reset_level_select_s = pin_lvl[6];

  // ----------------------------------------------------------------
  // effective shift clock
  // ----------------------------------------------------------------
  logic eff_clk_q;
  logic eff_clk_d;
  logic shift_en;

  always_comb begin
    eff_clk_d = sel_n_s | sclk_s;
  end

  // select rise with clock low also counts
  assign shift_en = eff_clk_d & ~eff_clk_q;

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  ddsl_pkg::ddsl_frame_t shift_q;
  ddsl_pkg::ddsl_frame_t shift_d;

  always_comb begin
    shift_d = shift_q;
    if (shift_en) begin
      shift_d = {shift_q[FRAME_BITS-2:0], sdi_s};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      eff_clk_q <= 1'b1;
      shift_q   <= '0;
    end else begin
      eff_clk_q <= eff_clk_d;
      shift_q   <= shift_d;
    end
  end

  // ----------------------------------------------------------------
  // input and output registers
  // ----------------------------------------------------------------
  function automatic ddsl_pkg::ddsl_dest_t dest_of(input ddsl_pkg::ddsl_frame_t f);
    if (f[`DDSL_BOTH_POS]) begin
      dest_of = ddsl_pkg::DDSL_DEST_BOTH;
    end else if (f[`DDSL_CHSEL_POS]) begin
      dest_of = ddsl_pkg::DDSL_DEST_B;
    end else begin
      dest_of = ddsl_pkg::DDSL_DEST_A;
    end
  endfunction : dest_of

  ddsl_pkg::ddsl_code_t in_a_q;
  ddsl_pkg::ddsl_code_t in_b_q;
  ddsl_pkg::ddsl_code_t out_a_q;
  ddsl_pkg::ddsl_code_t out_b_q;
  ddsl_pkg::ddsl_code_t in_a_d;
  ddsl_pkg::ddsl_code_t in_b_d;
  ddsl_pkg::ddsl_code_t out_a_d;
  ddsl_pkg::ddsl_code_t out_b_d;
  ddsl_pkg::ddsl_dest_t dest;
  ddsl_pkg::ddsl_code_t rst_code;
  logic                 soft_rst;
  logic                 sw_reset_level_select_q;

  assign dest = dest_of(shift_d);

  always_comb begin
    rst_code = (reset_level_select_s | sw_reset_level_select_q) ? `DDSL_MID_CODE : `DDSL_ZERO_CODE;
  end

  always_comb begin
    in_a_d  = in_a_q;
    in_b_d  = in_b_q;
    out_a_d = out_a_q;
    out_b_d = out_b_q;
    if (rst_rise || soft_rst) begin
      in_a_d  = rst_code;
      in_b_d  = rst_code;
      out_a_d = rst_code;
      out_b_d = rst_code;
    end else begin
      if (!load_n_s) begin
        if (dest == ddsl_pkg::DDSL_DEST_A || dest == ddsl_pkg::DDSL_DEST_BOTH) begin
          in_a_d = shift_d[`DDSL_CODE_MSB:0];
        end
        if (dest == ddsl_pkg::DDSL_DEST_B || dest == ddsl_pkg::DDSL_DEST_BOTH) begin
          in_b_d = shift_d[`DDSL_CODE_MSB:0];
        end
      end
      if (upd_rise) begin
        out_a_d = in_a_q;
        out_b_d = in_b_q;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      in_a_q  <= `DDSL_ZERO_CODE;
      in_b_q  <= `DDSL_ZERO_CODE;
      out_a_q <= `DDSL_ZERO_CODE;
      out_b_q <= `DDSL_ZERO_CODE;
    end else begin
      in_a_q  <= in_a_d;
      in_b_q  <= in_b_d;
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic sdo_q;
  logic sdo_d;

  always_comb begin
    sdo_d = shift_d[FRAME_BITS-1];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  assign serial_out_o = sdo_q;
  assign code_a_o     = out_a_q;
  assign code_b_o     = out_b_q;

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  // reads answer one cycle late so readdata is a flop; writes land one cycle after that answer
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        sw_reset_level_select_d;
  logic        soft_rst_q;
  logic        soft_rst_d;
  logic        req;

  assign req      = avs_read | avs_write;
  assign soft_rst = soft_rst_q;

  always_comb begin
    wait_d      = 1'b1;
    rdata_d     = rdata_q;
    sw_reset_level_select_d = sw_reset_level_select_q;
    soft_rst_d  = 1'b0;
    if (req && wait_q) begin
      wait_d = 1'b0;
      if (avs_address == `DDSL_OFF_CTRL) begin
        rdata_d = {30'h0, sw_reset_level_select_q, 1'b0};
      end else if (avs_address == `DDSL_OFF_STATUS) begin
        rdata_d = {25'h0, pin_lvl};
      end else if (avs_address == `DDSL_OFF_SHIFT) begin
        rdata_d = {8'h0, shift_q};
      end else if (avs_address == `DDSL_OFF_IN_A) begin
        rdata_d = {16'h0, in_a_q};
      end else if (avs_address == `DDSL_OFF_IN_B) begin
        rdata_d = {16'h0, in_b_q};
      end else if (avs_address == `DDSL_OFF_OUT_A) begin
        rdata_d = {16'h0, out_a_q};
      end else if (avs_address == `DDSL_OFF_OUT_B) begin
        rdata_d = {16'h0, out_b_q};
      end else begin
        rdata_d = `DDSL_BAD_ADDR_DATA;
      end
    end
    if (avs_write && !wait_q && avs_address == `DDSL_OFF_CTRL && avs_byteenable[0]) begin
      soft_rst_d  = avs_writedata[`DDSL_CTRL_SOFT_RST];
      sw_reset_level_select_d = avs_writedata[`DDSL_CTRL_RSTSELSW];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wait_q      <= 1'b1;
      rdata_q     <= '0;
      sw_reset_level_select_q <= 1'b0;
      soft_rst_q  <= 1'b0;
    end else begin
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
      sw_reset_level_select_q <= sw_reset_level_select_d;
      soft_rst_q  <= soft_rst_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_update_edge;
    upd_rise && !rst_rise && !soft_rst;
  endsequence

  property p_update_copies;
    @(posedge clock_i) disable iff (rst_i)
    s_update_edge |=> (out_a_q == $past(in_a_q)) && (out_b_q == $past(in_b_q));
  endproperty
  a_update_copies: assert property (p_update_copies) else $error("update missed");

  property p_out_stable;
    @(posedge clock_i) disable iff (rst_i)
    (!upd_rise && !rst_rise && !soft_rst) |=> $stable(out_a_q) && $stable(out_b_q);
  endproperty
  a_out_stable: assert property (p_out_stable) else $error("output moved");

  property p_shift_in;
    @(posedge clock_i) disable iff (rst_i)
    shift_en |=> shift_q[0] == $past(sdi_s);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift wrong");

  property p_shift_hold;
    @(posedge clock_i) disable iff (rst_i)
    !(sel_n_s | sclk_s) ##1 !(sel_n_s | sclk_s) |=> $stable(shift_q);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("spurious shift");

  property p_reset_keeps_shift;
    @(posedge clock_i) disable iff (rst_i)
    (rst_rise && !shift_en) |=> $stable(shift_q);
  endproperty
  a_reset_keeps_shift: assert property (p_reset_keeps_shift) else $error("shift hit");

  property p_reset_zero;
    @(posedge clock_i) disable iff (rst_i)
    (rst_rise && !reset_level_select_s && !sw_reset_level_select_q) |=> out_a_q == 16'h0000 && in_b_q == 16'h0000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("zero reset bad");

  property p_reset_mid;
    @(posedge clock_i) disable iff (rst_i)
    (rst_rise && reset_level_select_s) |=> out_b_q == 16'h8000 && in_a_q == 16'h8000;
  endproperty
  a_reset_mid: assert property (p_reset_mid) else $error("mid reset bad");

  property p_load_a;
    @(posedge clock_i) disable iff (rst_i)
    (!load_n_s && !rst_rise && !soft_rst && !shift_d[21] && !shift_d[23])
      |=> in_a_q == $past(shift_d[15:0]) && $stable(in_b_q);
  endproperty
  a_load_a: assert property (p_load_a) else $error("load a bad");

  property p_load_both;
    @(posedge clock_i) disable iff (rst_i)
    (!load_n_s && !rst_rise && !soft_rst && shift_d[21])
      |=> in_a_q == in_b_q;
  endproperty
  a_load_both: assert property (p_load_both) else $error("both load bad");

  property p_sdo;
    @(posedge clock_i) disable iff (rst_i)
    shift_en |=> serial_out_o == $past(shift_q[22]);
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial out bad");

endmodule : ddsl_core
`default_nettype wire

// >>> ddsl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host controller on the serial link and strobes
// ----------------------------------------------------------------
module ddsl_host_model (
  // serial link
  output logic select_n_o,
  output logic serial_clk_o,
  output logic serial_in_o,
  // strobes and reset
  output logic load_n_o,
  output logic update_o,
  output logic dev_reset_o,
  output logic level_sel_o,
  // chain return from the block
  input  wire logic serial_out_i
);
  // skew keeps link edges off the system clock edges
  localparam int SKEW = 37;
  localparam int HALF = 400;
  // shift register of the next device in a chain
  logic [23:0] chain_q;

  initial begin
    select_n_o   = 1'b1;
    serial_clk_o = 1'b1;
    serial_in_o  = 1'b0;
    load_n_o     = 1'b1;
    update_o     = 1'b0;
    dev_reset_o  = 1'b0;
    level_sel_o  = 1'b0;
  end

  task automatic send_frame(input logic [47:0] f, input int nbits, input bit bad_end);
    #SKEW;
    select_n_o = 1'b0;
    #HALF;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_clk_o = 1'b0;
      serial_in_o  = f[i];
      #HALF;
      chain_q      = {chain_q[22:0], serial_out_i};
      serial_clk_o = 1'b1;
      #HALF;
    end
    // released data shows the inverse, never the last bit
    serial_in_o = ~f[0];
    // select rises with clock high unless told to misbehave
    if (bad_end) begin
      serial_clk_o = 1'b0;
      #HALF;
    end
    select_n_o = 1'b1;
    #HALF;
    serial_clk_o = 1'b1;
    #HALF;
  endtask : send_frame

  task automatic send_by_select(input logic [23:0] f);
    #SKEW;
    serial_clk_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      select_n_o  = 1'b0;
      serial_in_o = f[i];
      #HALF;
      select_n_o = 1'b1;
      #HALF;
    end
    serial_in_o  = ~f[0];
    serial_clk_o = 1'b1;
    #HALF;
  endtask : send_by_select

  task automatic load_pulse();
    #SKEW;
    load_n_o = 1'b0;
    #(2 * HALF);
    load_n_o = 1'b1;
    #HALF;
  endtask : load_pulse

  task automatic update(input logic v);
    #SKEW;
    update_o = v;
    #(2 * HALF);
  endtask : update

  task automatic dev_reset(input logic level);
    #SKEW;
    level_sel_o = level;
    #HALF;
    dev_reset_o = 1'b1;
    #(2 * HALF);
    dev_reset_o = 1'b0;
    #HALF;
  endtask : dev_reset
endmodule : ddsl_host_model
`default_nettype wire

// >>> tb_dual_dac_serial_load_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddsl_params.svh"
module tb_dual_dac_serial_load_logic;
  logic                 clock_i, rst_i;
  logic                 select_n, serial_clk, serial_in, load_n, update, dev_reset, level_sel;
  logic                 serial_out;
  ddsl_pkg::ddsl_code_t code_a, code_b, ina, inb, oa, ob;
  logic [3:0]           avs_address, avs_byteenable;
  logic                 avs_read, avs_write, avs_waitrequest;
  logic [31:0]          avs_writedata, avs_readdata, last_codes, seed, r;
  logic [31:0]          code_q[$];
  logic [31:0]          word_q[$];
  logic [23:0]          f;
  int                   num_errors, checked;

  ddsl_core ddsl_core_i (
    .clock_i(clock_i), .rst_i(rst_i), .select_n_i(select_n), .serial_clk_i(serial_clk),
    .serial_in_i(serial_in), .load_n_i(load_n), .output_update_strobe_i(update),
    .dev_reset_i(dev_reset), .reset_level_select_i(level_sel), .serial_out_o(serial_out),
    .code_a_o(code_a), .code_b_o(code_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  ddsl_host_model ddsl_host_model_i (
    .select_n_o(select_n), .serial_clk_o(serial_clk), .serial_in_o(serial_in),
    .load_n_o(load_n), .update_o(update), .dev_reset_o(dev_reset), .level_sel_o(level_sel),
    .serial_out_i(serial_out));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk

  // a code change with no note queued is itself a mismatch
  always @(posedge clock_i) begin
    if ({code_a, code_b} !== last_codes) begin
      chk("codes", (code_q.size() > 0) ? code_q.pop_front() : last_codes, {code_a, code_b});
      last_codes = {code_a, code_b};
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk("readdata", word_q.pop_front(), avs_readdata);
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic expect_out();
    if ({ina, inb} !== {oa, ob}) code_q.push_back({ina, inb});
    oa = ina;
    ob = inb;
  endtask : expect_out

  task automatic set_in(input ddsl_pkg::ddsl_code_t v);
    ina = v;
    inb = v;
    expect_out();
  endtask : set_in

  task automatic drain();
    int n;
    n = 0;
    while (code_q.size() > 0 && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    if (code_q.size() > 0) begin
      num_errors++;
      complete_run();
    end
  endtask : drain

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_address   <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      complete_run();
    end
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    word_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hafc42aab;
    rst_i = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    num_errors = 0;
    checked = 0;
    last_codes = 'x;
    set_in(`DDSL_ZERO_CODE);
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`DDSL_OFF_OUT_A, 32'h0);
    rd(4'h9, `DDSL_BAD_ADDR_DATA);
    set_in(`DDSL_MID_CODE);
    ddsl_host_model_i.dev_reset(1'b1);
    drain();
    // every select and both-flag combination, junk in ignored bits
    for (int m = 0; m < 4; m++) begin
      r = $random(seed);
      f = {m[0], r[16], m[1], r[21:17], r[15:0]};
      ddsl_host_model_i.send_frame({24'h0, f}, 24, 1'b0);
      chk("serial_out", {31'h0, m[0]}, {31'h0, serial_out});
      ddsl_host_model_i.load_pulse();
      if (m[1] || !m[0]) ina = r[15:0];
      if (m[1] || m[0]) inb = r[15:0];
      rd(`DDSL_OFF_IN_A, {16'h0, ina});
      rd(`DDSL_OFF_IN_B, {16'h0, inb});
      rd(`DDSL_OFF_OUT_A, {16'h0, oa});
      expect_out();
      ddsl_host_model_i.update(1'b1);
      ddsl_host_model_i.update(1'b0);
      drain();
    end
    // select alone as shift clock, then two frames through a chain
    r = $random(seed);
    f = r[23:0];
    ddsl_host_model_i.send_by_select(f);
    rd(`DDSL_OFF_SHIFT, {8'h0, f});
    r = $random(seed);
    ddsl_host_model_i.send_frame({f, r[23:0]}, 48, 1'b0);
    chk("chain", {8'h0, f}, {8'h0, ddsl_host_model_i.chain_q});
    rd(`DDSL_OFF_SHIFT, {8'h0, r[23:0]});
    // strobe held high while input A is rewritten
    ddsl_host_model_i.update(1'b1);
    r = $random(seed);
    f = {8'h00, r[15:0]};
    ddsl_host_model_i.send_frame({24'h0, f}, 24, 1'b0);
    ddsl_host_model_i.load_pulse();
    ina = r[15:0];
    rd(`DDSL_OFF_OUT_A, {16'h0, oa});
    ddsl_host_model_i.update(1'b0);
    expect_out();
    ddsl_host_model_i.update(1'b1);
    ddsl_host_model_i.update(1'b0);
    drain();
    ddsl_host_model_i.send_frame({24'h0, f}, 24, 1'b1);
    rd(`DDSL_OFF_SHIFT, {8'h0, f[22:0], ~f[0]});
    set_in(`DDSL_ZERO_CODE);
    ddsl_host_model_i.dev_reset(1'b0);
    drain();
    rd(`DDSL_OFF_SHIFT, {8'h0, f[22:0], ~f[0]});
    bus(1'b1, `DDSL_OFF_CTRL, 32'h2);
    rd(`DDSL_OFF_CTRL, 32'h2);
    set_in(`DDSL_MID_CODE);
    bus(1'b1, `DDSL_OFF_CTRL, 32'h3);
    drain();
    bus(1'b1, `DDSL_OFF_CTRL, 32'h0);
    // a control write without its low byte lane is ignored
    avs_byteenable <= 4'he;
    bus(1'b1, `DDSL_OFF_CTRL, 32'h3);
    avs_byteenable <= 4'hf;
    rd(`DDSL_OFF_CTRL, 32'h0);
    complete_run();
  end
endmodule : tb_dual_dac_serial_load_logic
`default_nettype wire
